// ### cal_engine.sv
// shared multiply-add calibrator, one channel at a time
`timescale 1ns/100ps
`default_nettype none
module cal_engine
  import dac_bank_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // calibration requests and answers
  cal_if.engine     cal
);

  typedef struct packed {
    cal_state_t        st;
    logic [CODE_W-1:0] x;
    logic [CODE_W-1:0] gain;
    logic [CODE_W-1:0] offset;
    logic [CH_W-1:0]   ch;
    logic              bank;
    logic [PROD_W-1:0] prod;
    logic [CODE_W-1:0] res;
  } eng_t;

  eng_t st_q;
  eng_t st_d;

  // ------------------------------------------------------------------
  // sequencer: multiply and add split over two cycles to keep paths short
  // ------------------------------------------------------------------
  always_comb begin
    logic signed [SUM_W-1:0] sum;
    sum = '0;
    st_d = st_q;
    case (st_q.st)
      CAL_IDLE: begin
        if (cal.req_valid) begin  // operands are frozen here; later writes requeue
          st_d.x      = cal.req_x;
          st_d.gain   = cal.req_gain;
          st_d.offset = cal.req_offset;
          st_d.ch     = cal.req_ch;
          st_d.bank   = cal.req_bank;
          st_d.st     = CAL_MUL;
        end
      end
      CAL_MUL: begin
        st_d.prod = PROD_W'(st_q.x) * PROD_W'({1'b0, st_q.gain} + GAIN_ONE);
        st_d.st   = CAL_ADD;
      end
      CAL_ADD: begin
        sum = $signed({3'b000, st_q.prod[PROD_W-1:GAIN_SHIFT]})
            + $signed({4'h0, st_q.offset}) - $signed(MID_SHIFT);
        if (sum < 0) begin
          st_d.res = '0;
        end else if (sum > $signed({4'h0, CODE_MAX})) begin
          st_d.res = CODE_MAX;
        end else begin
          st_d.res = sum[CODE_W-1:0];
        end
        st_d.st = CAL_OUT;
      end
      CAL_OUT: begin
        st_d.st = CAL_IDLE;
      end
      default: begin
        st_d.st = CAL_IDLE;
      end
    endcase
    if (rst) begin
      st_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // answers come straight from the state register
  assign cal.req_ready = (st_q.st == CAL_IDLE);
  assign cal.rsp_valid = (st_q.st == CAL_OUT);
  assign cal.rsp_data  = st_q.res;
  assign cal.rsp_ch    = st_q.ch;
  assign cal.rsp_bank  = st_q.bank;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_accept;
    cal.req_valid && cal.req_ready;
  endsequence
  sequence s_answer(logic [CH_W-1:0] c);
    ##3 (cal.rsp_valid && cal.rsp_ch == c);
  endsequence

  property p_one_answer;
    logic [CH_W-1:0] c;
    (s_accept, c = cal.req_ch) |-> s_answer(c);
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("calibrator did not answer three cycles after accepting");

  property p_sat_high;
    s_accept ##0 (cal.req_x == CODE_MAX && cal.req_gain == CODE_MAX
                  && cal.req_offset == CODE_MAX) |-> ##3 (cal.rsp_data == CODE_MAX);
  endproperty
  a_sat_high: assert property (p_sat_high)
    else $error("full-scale operands did not saturate high");

  property p_sat_low;
    s_accept ##0 (cal.req_x == '0 && cal.req_offset == '0) |-> ##3 (cal.rsp_data == '0);
  endproperty
  a_sat_low: assert property (p_sat_low)
    else $error("negative result did not saturate to zero");

endmodule : cal_engine
`default_nettype wire

// ### cal_if.sv
// request and answer signals between the register bank and the calibrator
`timescale 1ns/100ps
`default_nettype none
interface cal_if;
  import dac_bank_pkg::*;

  logic              req_valid;
  logic              req_ready;
  logic [CODE_W-1:0] req_x;
  logic [CODE_W-1:0] req_gain;
  logic [CODE_W-1:0] req_offset;
  logic [CH_W-1:0]   req_ch;
  logic              req_bank;
  logic              rsp_valid;
  logic [CODE_W-1:0] rsp_data;
  logic [CH_W-1:0]   rsp_ch;
  logic              rsp_bank;

  modport issuer (
    output req_valid, req_x, req_gain, req_offset, req_ch, req_bank,
    input  req_ready, rsp_valid, rsp_data, rsp_ch, rsp_bank
  );
  modport engine (
    input  req_valid, req_x, req_gain, req_offset, req_ch, req_bank,
    output req_ready, rsp_valid, rsp_data, rsp_ch, rsp_bank
  );
endinterface : cal_if
`default_nettype wire

// ### dac_bank_pkg.sv
// constants, encodings and types shared by the converter channel register bank
package dac_bank_pkg;

  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  localparam int NUM_CH   = 40;
  localparam int GRP_SIZE = 8;
  localparam int NUM_GRP  = 5;
  localparam int NUM_OFS  = 3;
  localparam int CODE_W   = 14;
  localparam int CH_W     = 6;
  localparam int KIND_W   = 4;
  localparam int CTRL_W   = 3;
  localparam int PROD_W   = 29;
  localparam int SUM_W    = 18;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [CODE_W-1:0] INPUT_RST   = 14'h1555;
  localparam logic [CODE_W-1:0] GAIN_RST    = 14'h3fff;
  localparam logic [CODE_W-1:0] OFFSET_RST  = 14'h2000;
  localparam logic [CODE_W-1:0] GRP_OFS_RST = 14'h1555;
  localparam logic [CODE_W-1:0] CAL_RST     = 14'h1555;  // what the defaults calibrate to
  localparam logic [CTRL_W-1:0] CTRL_RST    = 3'h0;
  localparam logic [7:0]        SRCSEL_RST  = 8'h00;

  // ------------------------------------------------------------------
  // calibration arithmetic
  // ------------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_MAX   = 14'h3fff;
  localparam logic [14:0]       GAIN_ONE   = 15'h0001;
  localparam logic [SUM_W-1:0]  MID_SHIFT  = 18'h0_2000;
  localparam int                GAIN_SHIFT = 14;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_PD_BIT  = 0;
  localparam int CTRL_TS_BIT  = 1;
  localparam int CTRL_SEL_BIT = 2;

  // ------------------------------------------------------------------
  // register kinds on the host write/read port
  // ------------------------------------------------------------------
  localparam logic [KIND_W-1:0] K_IN_FIRST   = 4'h0;
  localparam logic [KIND_W-1:0] K_IN_SECOND  = 4'h1;
  localparam logic [KIND_W-1:0] K_IN_SEL     = 4'h2;
  localparam logic [KIND_W-1:0] K_GAIN       = 4'h3;
  localparam logic [KIND_W-1:0] K_OFFSET     = 4'h4;
  localparam logic [KIND_W-1:0] K_GRP_OFS    = 4'h5;
  localparam logic [KIND_W-1:0] K_CONTROL    = 4'h6;
  localparam logic [KIND_W-1:0] K_SRCSEL     = 4'h7;
  localparam logic [KIND_W-1:0] K_SRCSEL_ALL = 4'h8;

  // calibrator sequence, gray coded
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_MUL  = 2'h1,
    CAL_ADD  = 2'h3,
    CAL_OUT  = 2'h2
  } cal_state_t;

endpackage : dac_bank_pkg

// ### dac_channel_bank.sv
// converter channel data, trim, calibrated and final code registers
`timescale 1ns/100ps
`default_nettype none
module dac_channel_bank
  import dac_bank_pkg::*;
(
  // clock and reset
  input  wire logic                           SYS_CLK,
  input  wire logic                           RESET,
  // register writes
  input  wire logic                           WR_EN,
  input  wire logic [KIND_W-1:0]              WR_KIND,
  input  wire logic [CH_W-1:0]                WR_CH,
  input  wire logic [CODE_W-1:0]              WR_DATA,
  // register reads
  input  wire logic                           RD_EN,
  input  wire logic [KIND_W-1:0]              RD_KIND,
  input  wire logic [CH_W-1:0]                RD_CH,
  output logic      [CODE_W-1:0]              RD_DATA,
  output logic                                RD_VALID,
  // converter load strobe, active low
  input  wire logic                           LOAD_CONVERTER_N,
  // converter side
  output logic      [NUM_CH-1:0][CODE_W-1:0]  DAC_CODE,
  output logic      [NUM_GRP-1:0][CODE_W-1:0] GROUP_LEVEL,
  output logic                                POWER_DOWN,
  output logic                                THERMAL_EN,
  output logic                                BUSY
);

  typedef struct packed {
    logic [NUM_CH-1:0][CODE_W-1:0]   in_first;
    logic [NUM_CH-1:0][CODE_W-1:0]   in_second;
    logic [NUM_CH-1:0][CODE_W-1:0]   gain;
    logic [NUM_CH-1:0][CODE_W-1:0]   offset;
    logic [NUM_CH-1:0][CODE_W-1:0]   cal_a;
    logic [NUM_CH-1:0][CODE_W-1:0]   cal_b;
    logic [NUM_CH-1:0][CODE_W-1:0]   dac;
    logic [NUM_OFS-1:0][CODE_W-1:0]  grp_ofs;
    logic [CTRL_W-1:0]               ctrl;
    logic [NUM_GRP-1:0][GRP_SIZE-1:0] srcsel;
    logic [NUM_CH-1:0]               pend_a;
    logic [NUM_CH-1:0]               pend_b;
    logic [CODE_W-1:0]               rd_data;
    logic                            rd_valid;
    logic                            busy;
  } bank_t;

  bank_t st_q;
  bank_t st_d;

  cal_if cal ();

  logic [NUM_CH-1:0][CODE_W-1:0] sel_cal;
  logic                          wr_ok;
  logic                          rd_ok;
  logic                          sel_bit;
  logic                          issue_bank;
  logic [CH_W-1:0]               issue_ch;

  // ------------------------------------------------------------------
  // shared calibrator
  // ------------------------------------------------------------------
  cal_engine u_cal (
    .clk (SYS_CLK),
    .rst (RESET),
    .cal (cal)
  );

  // lowest pending channel wins; first bank drains before the second
  function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] v);
    logic [CH_W-1:0] idx;
    idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CH_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  assign wr_ok      = WR_CH < CH_W'(NUM_CH);
  assign rd_ok      = RD_CH < CH_W'(NUM_CH);
  assign sel_bit    = st_q.ctrl[CTRL_SEL_BIT];
  assign issue_bank = ~|st_q.pend_a;
  assign issue_ch   = first_set(issue_bank ? st_q.pend_b : st_q.pend_a);

  // request operands read straight from the stored input and trims
  assign cal.req_valid  = |{st_q.pend_a, st_q.pend_b};
  assign cal.req_bank   = issue_bank;
  assign cal.req_ch     = issue_ch;
  assign cal.req_x      = issue_bank ? st_q.in_second[issue_ch] : st_q.in_first[issue_ch];
  assign cal.req_gain   = st_q.gain[issue_ch];
  assign cal.req_offset = st_q.offset[issue_ch];

  // ------------------------------------------------------------------
  // per-channel source mux and per-group offset level
  // ------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    // bit n of group g steers channel 8g+n
    assign sel_cal[i] = st_q.srcsel[i / GRP_SIZE][i % GRP_SIZE]
                      ? st_q.cal_b[i] : st_q.cal_a[i];
  end

  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    // groups two to four share the last offset level
    localparam int OI = (g < NUM_OFS - 1) ? g : NUM_OFS - 1;
    assign GROUP_LEVEL[g] = st_q.grp_ofs[OI];
  end

  // ------------------------------------------------------------------
  // next state: queue, host writes, calibrated results, load, reads
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rd_valid = 1'b0;

    // retire the issued entry first so a write in the same cycle re-arms it
    if (cal.req_valid && cal.req_ready) begin
      if (issue_bank) begin
        st_d.pend_b[issue_ch] = 1'b0;
      end else begin
        st_d.pend_a[issue_ch] = 1'b0;
      end
    end

    // host writes; channels 40 to 63 are ignored
    if (WR_EN) begin
      case (WR_KIND)
        K_IN_FIRST: begin
          if (wr_ok) begin
            st_d.in_first[WR_CH] = WR_DATA;
            st_d.pend_a[WR_CH] = 1'b1;
          end
        end
        K_IN_SECOND: begin
          if (wr_ok) begin
            st_d.in_second[WR_CH] = WR_DATA;
            st_d.pend_b[WR_CH] = 1'b1;
          end
        end
        K_IN_SEL: begin
          if (wr_ok && sel_bit) begin
            st_d.in_second[WR_CH] = WR_DATA;
            st_d.pend_b[WR_CH] = 1'b1;
          end else if (wr_ok) begin
            st_d.in_first[WR_CH] = WR_DATA;
            st_d.pend_a[WR_CH] = 1'b1;
          end
        end
        K_GAIN, K_OFFSET: begin
          if (wr_ok) begin
            if (WR_KIND == K_GAIN) begin
              st_d.gain[WR_CH] = WR_DATA;
            end else begin
              st_d.offset[WR_CH] = WR_DATA;
            end
            // the select bit decides which calibrated copy follows the trim
            if (sel_bit) begin
              st_d.pend_b[WR_CH] = 1'b1;
            end else begin
              st_d.pend_a[WR_CH] = 1'b1;
            end
          end
        end
        K_GRP_OFS: begin
          if (WR_CH < CH_W'(NUM_OFS)) begin
            st_d.grp_ofs[WR_CH] = WR_DATA;
          end
        end
        K_CONTROL: begin
          st_d.ctrl = WR_DATA[CTRL_W-1:0];
        end
        K_SRCSEL: begin
          if (WR_CH < CH_W'(NUM_GRP)) begin
            st_d.srcsel[WR_CH] = WR_DATA[GRP_SIZE-1:0];
          end
        end
        K_SRCSEL_ALL: begin
          st_d.srcsel = {(NUM_GRP * GRP_SIZE){WR_DATA[0]}};
        end
        default: begin
          st_d.ctrl = st_q.ctrl;  // unmapped kinds are dropped
        end
      endcase
    end

    // calibrated results land in the copy they were computed for
    if (cal.rsp_valid) begin
      if (cal.rsp_bank) begin
        st_d.cal_b[cal.rsp_ch] = cal.rsp_data;
      end else begin
        st_d.cal_a[cal.rsp_ch] = cal.rsp_data;
      end
    end

    // while the load input is low every cycle copies the selected data
    if (!LOAD_CONVERTER_N) begin
      st_d.dac = sel_cal;
    end

    // reads; calibrated and final codes are not visible, they answer zero
    if (RD_EN) begin
      st_d.rd_valid = 1'b1;
      st_d.rd_data  = '0;
      case (RD_KIND)
        K_IN_FIRST:  st_d.rd_data = rd_ok ? st_q.in_first[RD_CH] : '0;
        K_IN_SECOND: st_d.rd_data = rd_ok ? st_q.in_second[RD_CH] : '0;
        K_IN_SEL: begin
          if (rd_ok) begin
            st_d.rd_data = sel_bit ? st_q.in_second[RD_CH] : st_q.in_first[RD_CH];
          end
        end
        K_GAIN:      st_d.rd_data = rd_ok ? st_q.gain[RD_CH] : '0;
        K_OFFSET:    st_d.rd_data = rd_ok ? st_q.offset[RD_CH] : '0;
        K_GRP_OFS: begin
          if (RD_CH < CH_W'(NUM_OFS)) begin
            st_d.rd_data = st_q.grp_ofs[RD_CH];
          end
        end
        K_CONTROL:   st_d.rd_data = CODE_W'(st_q.ctrl);
        K_SRCSEL: begin
          if (RD_CH < CH_W'(NUM_GRP)) begin
            st_d.rd_data = CODE_W'(st_q.srcsel[RD_CH]);
          end
        end
        default:     st_d.rd_data = '0;
      endcase
    end

    // busy while work is queued or the calibrator holds a job
    st_d.busy = |{st_d.pend_a, st_d.pend_b} | ~cal.req_ready
              | (cal.req_valid & cal.req_ready);

    if (RESET) begin
      st_d         = '0;
      st_d.in_first  = {NUM_CH{INPUT_RST}};
      st_d.in_second = {NUM_CH{INPUT_RST}};
      st_d.gain    = {NUM_CH{GAIN_RST}};
      st_d.offset  = {NUM_CH{OFFSET_RST}};
      st_d.cal_a   = {NUM_CH{CAL_RST}};
      st_d.cal_b   = {NUM_CH{CAL_RST}};
      st_d.dac     = {NUM_CH{CAL_RST}};
      st_d.grp_ofs = {NUM_OFS{GRP_OFS_RST}};
      st_d.ctrl    = CTRL_RST;
      st_d.srcsel  = {NUM_GRP{SRCSEL_RST}};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    st_q <= st_d;
  end

  // ------------------------------------------------------------------
  // outputs, each straight from the state register
  // ------------------------------------------------------------------
  assign RD_DATA    = st_q.rd_data;
  assign RD_VALID   = st_q.rd_valid;
  assign DAC_CODE   = st_q.dac;
  assign POWER_DOWN = st_q.ctrl[CTRL_PD_BIT];
  assign THERMAL_EN = st_q.ctrl[CTRL_TS_BIT];
  assign BUSY       = st_q.busy;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  property p_first_rst;
    disable iff (1'b0) RESET |=> (st_q.in_first == {NUM_CH{INPUT_RST}});
  endproperty
  a_first_rst: assert property (p_first_rst)
    else $error("first input registers not at reset value");

  property p_second_rst;
    disable iff (1'b0) RESET |=> (st_q.in_second == {NUM_CH{INPUT_RST}});
  endproperty
  a_second_rst: assert property (p_second_rst)
    else $error("second input registers not at reset value");

  property p_trim_rst;
    disable iff (1'b0) RESET |=> (st_q.gain == {NUM_CH{GAIN_RST}});
  endproperty
  a_trim_rst: assert property (p_trim_rst)
    else $error("gain trims not at reset value");

  property p_offset_rst;
    disable iff (1'b0) RESET |=> (st_q.offset == {NUM_CH{OFFSET_RST}});
  endproperty
  a_offset_rst: assert property (p_offset_rst)
    else $error("offset trims not at reset value");

  property p_level_rst;
    disable iff (1'b0) RESET |=> (GROUP_LEVEL == {NUM_GRP{GRP_OFS_RST}});
  endproperty
  a_level_rst: assert property (p_level_rst)
    else $error("group offset levels not at reset value");

  property p_ctrl_rst;
    disable iff (1'b0) RESET |=> (!POWER_DOWN && !THERMAL_EN && st_q.ctrl == CTRL_RST);
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst)
    else $error("control register not cleared by reset");

  property p_srcsel_rst;
    disable iff (1'b0) RESET |=> (st_q.srcsel == '0);
  endproperty
  a_srcsel_rst: assert property (p_srcsel_rst)
    else $error("source select not cleared by reset");

  property p_thermal;
    (WR_EN && WR_KIND == K_CONTROL) |=> (THERMAL_EN == $past(WR_DATA[CTRL_TS_BIT]));
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("thermal enable does not follow control write");

  property p_powerdown;
    (WR_EN && WR_KIND == K_CONTROL) |=> (POWER_DOWN == $past(WR_DATA[CTRL_PD_BIT]));
  endproperty
  a_powerdown: assert property (p_powerdown)
    else $error("power-down does not follow control write");

  property p_trim_requeue;
    (WR_EN && WR_KIND == K_GAIN && wr_ok && !sel_bit)
      |=> st_q.pend_a[$past(WR_CH)];
  endproperty
  a_trim_requeue: assert property (p_trim_requeue)
    else $error("gain write with select low did not queue first copy");

  property p_no_loss;
    $fell(st_q.pend_a[3])
      |-> $past(cal.req_valid && cal.req_ready && !issue_bank && issue_ch == 6'd3);
  endproperty
  a_no_loss: assert property (p_no_loss)
    else $error("queued recalculation dropped without being issued");

  property p_hold;
    LOAD_CONVERTER_N |=> $stable(st_q.dac);
  endproperty
  a_hold: assert property (p_hold)
    else $error("final code changed while load input high");

  property p_group_map;
    !LOAD_CONVERTER_N |=> (DAC_CODE[20] ==
      $past(st_q.srcsel[2][4] ? st_q.cal_b[20] : st_q.cal_a[20]));
  endproperty
  a_group_map: assert property (p_group_map)
    else $error("channel 20 not fed from its group select bit");

  property p_load;
    !LOAD_CONVERTER_N |=> (DAC_CODE == $past(sel_cal));
  endproperty
  a_load: assert property (p_load)
    else $error("final codes not loaded while load input low");

  property p_hidden;
    (RD_EN && RD_KIND > K_SRCSEL) |=> (RD_VALID && RD_DATA == '0);
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("hidden register kind returned data");

endmodule : dac_channel_bank
`default_nettype wire

// ### host_model.sv
// host model: register writes, reads and the converter load line
`timescale 1ns/100ps
`default_nettype none
module host_model
  import dac_bank_pkg::*;
(
  // clock
  input  wire logic              clk,
  // register port
  output logic                   wr_en,
  output logic [KIND_W-1:0]      wr_kind,
  output logic [CH_W-1:0]        wr_ch,
  output logic [CODE_W-1:0]      wr_data,
  output logic                   rd_en,
  output logic [KIND_W-1:0]      rd_kind,
  output logic [CH_W-1:0]        rd_ch,
  input  wire logic [CODE_W-1:0] rd_data,
  input  wire logic              rd_valid,
  // converter load, active low
  output logic                   load_n
);
  // quiet bus at time zero
  initial begin
    {wr_en, wr_kind, wr_ch, wr_data, rd_en, rd_kind, rd_ch} = '0;
    load_n = 1'b1;
  end

  // one-cycle write; data is inverted after release so stale values never pass
  task automatic wr(input logic [KIND_W-1:0] k, input logic [CH_W-1:0] c,
                    input logic [CODE_W-1:0] d);
    @(negedge clk);
    {wr_en, wr_kind, wr_ch, wr_data} = {1'b1, k, c, d};
    @(negedge clk);
    wr_en = 1'b0;
    wr_data = ~d;
  endtask : wr

  // one-cycle read; answer is taken one cycle after the strobe
  task automatic rd(input logic [KIND_W-1:0] k, input logic [CH_W-1:0] c,
                    output logic [CODE_W-1:0] d, output logic v);
    @(negedge clk);
    {rd_en, rd_kind, rd_ch} = {1'b1, k, c};
    @(negedge clk);
    rd_en = 1'b0;
    v = rd_valid;
    d = rd_data;
  endtask : rd

  // load level; held low, every new result of the selected copy passes straight through
  task automatic load(input logic lvl);
    @(negedge clk);
    load_n = lvl;
  endtask : load
endmodule : host_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the converter channel register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dac_bank_pkg::*;
  logic                         sys_clk, reset, wr_en, rd_en, load_n, rd_valid;
  logic                         power_down, thermal_en, busy;
  logic [KIND_W-1:0]            wr_kind, rd_kind;
  logic [CH_W-1:0]              wr_ch, rd_ch;
  logic [CODE_W-1:0]            wr_data, rd_data, rdat;
  logic                         rval;
  logic [NUM_CH-1:0][CODE_W-1:0]  dac_code;
  logic [NUM_GRP-1:0][CODE_W-1:0] group_level;
  int                           num_errors = 0;
  int                           samples_checked = 0;

  dac_channel_bank uut (.SYS_CLK(sys_clk), .RESET(reset), .WR_EN(wr_en), .WR_KIND(wr_kind),
    .WR_CH(wr_ch), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_KIND(rd_kind), .RD_CH(rd_ch),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .LOAD_CONVERTER_N(load_n), .DAC_CODE(dac_code),
    .GROUP_LEVEL(group_level), .POWER_DOWN(power_down), .THERMAL_EN(thermal_en),
    .BUSY(busy));
  host_model h (.clk(sys_clk), .wr_en(wr_en), .wr_kind(wr_kind), .wr_ch(wr_ch),
    .wr_data(wr_data), .rd_en(rd_en), .rd_kind(rd_kind), .rd_ch(rd_ch),
    .rd_data(rd_data), .rd_valid(rd_valid), .load_n(load_n));

  // ----------------------------------------
  // compare, wait and verdict
  // ----------------------------------------
  task automatic chk(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a read must come back with its valid pulse
  task automatic rchk(input logic [KIND_W-1:0] k, input logic [CH_W-1:0] c,
                      input logic [CODE_W-1:0] exp);
    h.rd(k, c, rdat, rval);
    chk({13'h0, rval}, 14'h0001);
    chk(rdat, exp);
  endtask : rchk

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // bounded wait for the calibrator to drain, plus the load cycle
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(negedge sys_clk);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      tally_and_finish();
    end else begin
      @(negedge sys_clk);
    end
  endtask : settle

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // main sequence
  initial begin
    reset = 1'b1;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    rchk(K_IN_FIRST, 6'd0, 14'h1555);
    rchk(K_IN_SECOND, 6'd39, 14'h1555);
    rchk(K_GAIN, 6'd1, 14'h3fff);
    rchk(K_OFFSET, 6'd2, 14'h2000);
    for (int i = 0; i < NUM_OFS; i++) rchk(K_GRP_OFS, 6'(i), 14'h1555);
    rchk(K_CONTROL, 6'd0, 14'h0000);
    rchk(K_SRCSEL, 6'd4, 14'h0000);
    chk(dac_code[39], 14'h1555);
    h.wr(K_CONTROL, 6'd0, 14'h0003);
    chk({12'h0, thermal_en, power_down}, 14'h0003);
    h.wr(K_CONTROL, 6'd0, 14'h0000);
    // three channels queued behind each other, load held high
    h.wr(K_GAIN, 6'd3, 14'h1fff);
    h.wr(K_IN_FIRST, 6'd3, 14'h3000);
    h.wr(K_OFFSET, 6'd4, 14'h3fff);
    h.wr(K_IN_FIRST, 6'd4, 14'h3fff);
    h.wr(K_OFFSET, 6'd5, 14'h0000);
    h.wr(K_IN_FIRST, 6'd5, 14'h0000);
    chk({13'h0, busy}, 14'h0001);
    settle();
    chk({13'h0, busy}, 14'h0000);
    chk(dac_code[3], 14'h1555);
    h.load(1'b0);
    repeat (2) @(negedge sys_clk);
    chk(dac_code[3], 14'h1800);
    chk(dac_code[4], 14'h3fff);
    chk(dac_code[5], 14'h0000);
    // second copy through the select bit, load left low
    h.wr(K_CONTROL, 6'd0, 14'h0004);
    h.wr(K_IN_SEL, 6'd6, 14'h0100);
    h.wr(K_SRCSEL, 6'd0, 14'h0040);
    settle();
    rchk(K_IN_FIRST, 6'd6, 14'h1555);
    rchk(K_IN_SECOND, 6'd6, 14'h0100);
    chk(dac_code[6], 14'h0100);
    chk(dac_code[7], 14'h1555);
    // second copy of channel 7 by its own kind, then every select to the second copy
    h.wr(K_IN_SECOND, 6'd7, 14'h0200);
    chk({13'h0, busy}, 14'h0001);
    settle();
    chk(dac_code[7], 14'h1555);
    h.wr(K_SRCSEL_ALL, 6'd0, 14'h0001);
    rchk(K_SRCSEL, 6'd4, 14'h00ff);
    chk(dac_code[7], 14'h0200);
    rchk(K_SRCSEL_ALL, 6'd0, 14'h0000);
    h.wr(K_GRP_OFS, 6'd2, 14'h0abc);
    h.wr(K_GRP_OFS, 6'd3, 14'h0123);
    for (int g = 0; g < NUM_GRP; g++) chk(group_level[g], g < 2 ? 14'h1555 : 14'h0abc);
    h.wr(K_IN_FIRST, 6'd40, 14'h0077);
    rchk(K_IN_FIRST, 6'd40, 14'h0000);
    tally_and_finish();
  end

  // overall hang guard
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
